// [core/mcsb_pkg.sv]
// constants of the microcode store and its output buffer register
package mcsb_pkg;

    // --------------------------------------------------------------
    // store geometry
    // --------------------------------------------------------------
    localparam int unsigned WORD_BITS   = 68;
    localparam int unsigned STORE_DEPTH = 256;
    localparam int unsigned UADDR_BITS  = 8;
    localparam int unsigned SLICE_BITS  = 4;
    localparam int unsigned NUM_SLICES  = 16;
    localparam int unsigned TOP_LSB     = 64;

    // --------------------------------------------------------------
    // field positions in the control word
    // --------------------------------------------------------------
    localparam int unsigned FP_LSB      = 64;
    localparam int unsigned T2_LSB      = 46;
    localparam int unsigned T2_BITS     = 18;
    localparam int unsigned PAD_LSB     = 41;
    localparam int unsigned BUSG_LSB    = 35;
    localparam int unsigned SHC_HI_BIT  = 34;
    localparam int unsigned SHC_LO_BIT  = 33;
    localparam int unsigned BCT_LSB     = 28;
    localparam int unsigned MSC_LO_BIT  = 27;
    localparam int unsigned T1LO_LSB    = 15;
    localparam int unsigned FORK_C_BIT  = 14;
    localparam int unsigned FORK_B_BIT  = 13;
    localparam int unsigned FORK_A_BIT  = 12;
    localparam int unsigned BEF_LSB     = 8;
    localparam int unsigned NADDR_LSB   = 0;

    // --------------------------------------------------------------
    // timing: 200 MHz clock, pulses 15 ns wide every 30 ns
    // --------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS     = 5000;
    localparam int unsigned PULSE_WIDTH_NS    = 15;
    localparam int unsigned PULSE_INTERVAL_NS = 30;
    localparam int unsigned PULSE_WIDTH_CYC   = (PULSE_WIDTH_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned PULSE_INTERVAL_CYC = (PULSE_INTERVAL_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned NUM_PULSES_DEF    = 5;
    localparam int unsigned PHASE_BITS        = 8;

    // --------------------------------------------------------------
    // register map (byte addresses) and reset values
    // --------------------------------------------------------------
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_STATUS     = 8'h04;
    localparam logic [7:0]  OFS_CYCLES     = 8'h08;
    localparam int unsigned CTRL_RUN_BIT   = 0;
    localparam int unsigned CTRL_RST_LSB   = 8;
    localparam int unsigned STAT_PHASE_LSB = 8;
    localparam int unsigned STAT_CONF_BIT  = 16;
    localparam logic        RUN_RST        = 1'b1;
    localparam logic [7:0]  RESTART_RST    = 8'h00;
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;

    typedef enum logic [1:0] {
        SEL_CTRL   = 2'b00,
        SEL_STATUS = 2'b01,
        SEL_CYCLES = 2'b10,
        SEL_NONE   = 2'b11
    } mcsb_sel_t;

endpackage

// [core/mcsb_store.sv]
// microcode control store, staged output buffer and register slave
//
// Operation
// - 256 words of 68 bits, one read per cycle
// - state-only controls come from store outputs
// - seventeen 4-bit slices share one microaddress
// - groups captured at T1, T2, T1 trailing edge
// - pad enables and address latched at T1 end
// - bits 33 and 27 own flops, both polarities
// - next address internal; some branch enables doubled
// - fp_start, clear_sync, fp_control latched at T1
// - bus/source/destination register controls at T2
// - cc_load, pc, shifter, instr_reg controls at T2
// - bus_delay, busaddr_mux, internal_bus_sel at T1
// - shift, bus, misc, mux, alu fields at T1
// - fork, branch and next address fields unbuffered
// - microaddress loaded at T3, new word next T1/T2
// - pulses 15 ns wide, every 30 ns
// - next address field ORed with branch outputs
// - several forks enabled at once set the conflict flag
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ps

module mcsb_store #(
    parameter int unsigned                                      NUM_PULSES = mcsb_pkg::NUM_PULSES_DEF,
    parameter logic [mcsb_pkg::STORE_DEPTH*mcsb_pkg::WORD_BITS-1:0] ROM_IMAGE  = '0
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // register bus
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // sequencing inputs from branch and fork logic
    input  wire logic [7:0]  branch_mod,
    input  wire logic [7:0]  fork_a_addr,
    input  wire logic [7:0]  fork_b_addr,
    input  wire logic [7:0]  fork_c_addr,
    // unbuffered sequencing controls
    output logic             fork_a_enable,
    output logic             fork_b_enable,
    output logic             fork_c_enable,
    output logic [3:0]       branch_enable,
    output logic [2:0]       branch_enable_n,
    // timing pulses t1..tn
    output logic [NUM_PULSES-1:0] timing_pulse,
    // controls captured at t1
    output logic             fp_start,
    output logic             clear_sync,
    output logic [1:0]       fp_control,
    output logic [1:0]       bus_delay,
    output logic [1:0]       busaddr_mux,
    output logic [1:0]       internal_bus_sel,
    output logic [1:0]       shift_count_ctl,
    output logic             shift_count_ctl0_n,
    output logic [2:0]       bus_ctl,
    output logic [2:0]       misc_ctl,
    output logic             misc_ctl0_n,
    output logic [2:0]       bus_cond,
    output logic [1:0]       a_mux,
    output logic [1:0]       b_mux,
    output logic [1:0]       const_mux,
    output logic [2:0]       alu_ctl,
    // controls captured at the end of t1
    output logic [1:0]       gpr_write_enable,
    output logic [2:0]       scratchpad_addr,
    // controls captured at t2
    output logic             busreg_clk,
    output logic             busreg_mux,
    output logic [1:0]       srcreg_mux,
    output logic [1:0]       dstreg_mux,
    output logic             srcreg_clk,
    output logic [1:0]       dstreg_clk,
    output logic [2:0]       cc_load,
    output logic             pc_a_clk,
    output logic [1:0]       pc_b_clk,
    output logic [1:0]       shifter_ctl,
    output logic             instr_reg_clk
);
    // --------------------------------------------------------------
    // parameters and state
    // --------------------------------------------------------------
    localparam int unsigned CYC_LEN = NUM_PULSES * mcsb_pkg::PULSE_INTERVAL_CYC;
    localparam logic [7:0]  PH_T1E  = 8'(mcsb_pkg::PULSE_WIDTH_CYC);
    localparam logic [7:0]  PH_T2   = 8'(mcsb_pkg::PULSE_INTERVAL_CYC);
    localparam logic [7:0]  PH_T3   = 8'(2 * mcsb_pkg::PULSE_INTERVAL_CYC);
    localparam logic [7:0]  PH_LAST = 8'(CYC_LEN - 1);
    if (NUM_PULSES < 3 || CYC_LEN > 256) begin : g_bad_pulses
        $error("NUM_PULSES must be 3 or more and fit the phase counter");
    end
    typedef struct packed {
        logic [7:0]  uaddr;
        logic [7:0]  phase;
        logic [3:0]  fp;
        logic [17:0] t2grp;
        logic [4:0]  pad;
        logic [5:0]  busg;
        logic [5:0]  racc;
        logic        sc0;
        logic        msc0;
        logic [11:0] t1lo;
        logic        run;
        logic [7:0]  restart;
        logic        conflict;
        logic [31:0] cycles;
        logic        aw_got;
        logic [7:0]  awaddr;
        logic        w_got;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } mcsb_state_t;
    mcsb_state_t st_q;
    mcsb_state_t st_d;
    logic [mcsb_pkg::WORD_BITS-1:0] rom_word;
    logic [7:0]                     next_addr;
    logic                           cap_t1;
    logic                           cap_t1e;
    logic                           cap_t2;
    logic                           load_t3;
    function automatic mcsb_pkg::mcsb_sel_t reg_sel(input logic [7:0] a);
        case (a & 8'hfc)
            mcsb_pkg::OFS_CTRL:   reg_sel = mcsb_pkg::SEL_CTRL;
            mcsb_pkg::OFS_STATUS: reg_sel = mcsb_pkg::SEL_STATUS;
            mcsb_pkg::OFS_CYCLES: reg_sel = mcsb_pkg::SEL_CYCLES;
            default:              reg_sel = mcsb_pkg::SEL_NONE;
        endcase
    endfunction
    function automatic logic [3:0] rom_nib(input logic [7:0] a, input int unsigned bitpos);
        rom_nib = ROM_IMAGE[int'(a) * mcsb_pkg::WORD_BITS + bitpos +: 4];
    endfunction
    // --------------------------------------------------------------
    // control store slices
    // --------------------------------------------------------------
    for (genvar s = 0; s < mcsb_pkg::NUM_SLICES; s++) begin : g_slice
        assign rom_word[s*4 +: 4] = rom_nib(st_q.uaddr, s * 4);
    end
    assign rom_word[mcsb_pkg::TOP_LSB +: 4] = rom_nib(st_q.uaddr, mcsb_pkg::TOP_LSB);
    // --------------------------------------------------------------
    // timing pulses and capture strobes
    // --------------------------------------------------------------
    for (genvar p = 0; p < NUM_PULSES; p++) begin : g_pulse
        assign timing_pulse[p] = st_q.run
            && st_q.phase >= 8'(p * mcsb_pkg::PULSE_INTERVAL_CYC)
            && st_q.phase < 8'(p * mcsb_pkg::PULSE_INTERVAL_CYC
                               + mcsb_pkg::PULSE_WIDTH_CYC);
    end
    assign cap_t1  = st_q.run && st_q.phase == 8'h00;
    assign cap_t1e = st_q.run && st_q.phase == PH_T1E;
    assign cap_t2  = st_q.run && st_q.phase == PH_T2;
    assign load_t3 = st_q.run && st_q.phase == PH_T3;
    // --------------------------------------------------------------
    // next microaddress assembly
    // --------------------------------------------------------------
    assign next_addr = rom_word[mcsb_pkg::NADDR_LSB +: 8] | branch_mod
        | (fork_a_addr & {8{rom_word[mcsb_pkg::FORK_A_BIT]}})
        | (fork_b_addr & {8{rom_word[mcsb_pkg::FORK_B_BIT]}})
        | (fork_c_addr & {8{rom_word[mcsb_pkg::FORK_C_BIT]}});
    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        mcsb_pkg::mcsb_sel_t wsel;
        mcsb_pkg::mcsb_sel_t rsel;
        logic                fork_many;
        wsel      = reg_sel(st_q.awaddr);
        rsel      = reg_sel(s_axi_araddr);
        fork_many = $countones(rom_word[mcsb_pkg::FORK_C_BIT:mcsb_pkg::FORK_A_BIT]) > 1;
        st_d      = st_q;
        // timing generator
        if (!st_q.run) begin
            st_d.phase = 8'h00;
            st_d.uaddr = st_q.restart;
        end else begin
            st_d.phase = (st_q.phase == PH_LAST) ? 8'h00 : st_q.phase + 8'h01;
        end
        if (st_q.run && st_q.phase == PH_LAST) begin
            st_d.cycles = st_q.cycles + 32'h1;
        end
        // staged capture into the buffer register
        if (cap_t1) begin
            st_d.fp   = rom_word[mcsb_pkg::FP_LSB +: 4];
            st_d.busg = rom_word[mcsb_pkg::BUSG_LSB +: 6];
            st_d.racc = {rom_word[mcsb_pkg::SHC_HI_BIT],
                         rom_word[mcsb_pkg::BCT_LSB +: 5]};
            st_d.sc0  = rom_word[mcsb_pkg::SHC_LO_BIT];
            st_d.msc0 = rom_word[mcsb_pkg::MSC_LO_BIT];
            st_d.t1lo = rom_word[mcsb_pkg::T1LO_LSB +: 12];
        end
        if (cap_t1e) begin
            st_d.pad = rom_word[mcsb_pkg::PAD_LSB +: 5];
        end
        if (cap_t2) begin
            st_d.t2grp = rom_word[mcsb_pkg::T2_LSB +: mcsb_pkg::T2_BITS];
        end
        if (load_t3) begin
            st_d.uaddr = next_addr;
        end
        // write channel
        if (s_axi_awvalid && s_axi_awready) begin
            st_d.aw_got = 1'b1;
            st_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_d.w_got = 1'b1;
            st_d.wdata = s_axi_wdata;
            st_d.wstrb = s_axi_wstrb;
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        if (st_q.aw_got && st_q.w_got) begin
            st_d.aw_got = 1'b0;
            st_d.w_got  = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp  = mcsb_pkg::RESP_OKAY;
            case (wsel)
                mcsb_pkg::SEL_CTRL: begin
                    if (st_q.wstrb[0]) begin
                        st_d.run = st_q.wdata[mcsb_pkg::CTRL_RUN_BIT];
                    end
                    if (st_q.wstrb[1]) begin
                        st_d.restart = st_q.wdata[mcsb_pkg::CTRL_RST_LSB +: 8];
                    end
                end
                mcsb_pkg::SEL_STATUS: begin
                    if (st_q.wstrb[2] && st_q.wdata[mcsb_pkg::STAT_CONF_BIT]) begin
                        st_d.conflict = 1'b0;
                    end
                end
                mcsb_pkg::SEL_CYCLES: begin
                end
                default: begin
                    st_d.bresp = mcsb_pkg::RESP_SLVERR;
                end
            endcase
        end
        // fork conflict flag; a new event beats a clear
        if (fork_many) begin
            st_d.conflict = 1'b1;
        end
        // read channel
        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_d.rvalid = 1'b1;
            st_d.rresp  = mcsb_pkg::RESP_OKAY;
            st_d.rdata  = 32'h0;
            case (rsel)
                mcsb_pkg::SEL_CTRL: begin
                    st_d.rdata[mcsb_pkg::CTRL_RUN_BIT]     = st_q.run;
                    st_d.rdata[mcsb_pkg::CTRL_RST_LSB +: 8] = st_q.restart;
                end
                mcsb_pkg::SEL_STATUS: begin
                    st_d.rdata[7:0]                          = st_q.uaddr;
                    st_d.rdata[mcsb_pkg::STAT_PHASE_LSB +: 8] = st_q.phase;
                    st_d.rdata[mcsb_pkg::STAT_CONF_BIT]      = st_q.conflict;
                end
                mcsb_pkg::SEL_CYCLES: begin
                    st_d.rdata = st_q.cycles;
                end
                default: begin
                    st_d.rresp = mcsb_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (!aresetn) begin
            st_d          = '0;
            st_d.run      = mcsb_pkg::RUN_RST;
            st_d.restart  = mcsb_pkg::RESTART_RST;
            st_d.uaddr    = mcsb_pkg::RESTART_RST;
        end
    end
    always_ff @(posedge aclk) begin
        st_q <= st_d;
    end
    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign s_axi_awready = !st_q.aw_got && !st_q.bvalid;
    assign s_axi_wready  = !st_q.w_got && !st_q.bvalid;
    assign s_axi_bvalid  = st_q.bvalid;
    assign s_axi_bresp   = st_q.bresp;
    assign s_axi_arready = !st_q.rvalid;
    assign s_axi_rvalid  = st_q.rvalid;
    assign s_axi_rdata   = st_q.rdata;
    assign s_axi_rresp   = st_q.rresp;
    assign fork_a_enable   = rom_word[mcsb_pkg::FORK_A_BIT];
    assign fork_b_enable   = rom_word[mcsb_pkg::FORK_B_BIT];
    assign fork_c_enable   = rom_word[mcsb_pkg::FORK_C_BIT];
    assign branch_enable   = rom_word[mcsb_pkg::BEF_LSB +: 4];
    assign branch_enable_n = ~{rom_word[mcsb_pkg::BEF_LSB + 3],
                               rom_word[mcsb_pkg::BEF_LSB +: 2]};
    assign {fp_start, clear_sync, fp_control} = st_q.fp;
    assign {bus_delay, busaddr_mux, internal_bus_sel} = st_q.busg;
    assign shift_count_ctl    = {st_q.racc[5], st_q.sc0};
    assign shift_count_ctl0_n = ~st_q.sc0;
    assign bus_ctl            = st_q.racc[4:2];
    assign misc_ctl           = {st_q.racc[1:0], st_q.msc0};
    assign misc_ctl0_n        = ~st_q.msc0;
    assign {bus_cond, a_mux, b_mux, const_mux, alu_ctl} = st_q.t1lo;
    assign {gpr_write_enable, scratchpad_addr} = st_q.pad;
    assign {busreg_clk, busreg_mux, srcreg_mux, dstreg_mux, srcreg_clk, dstreg_clk,
            cc_load, pc_a_clk, pc_b_clk, shifter_ctl, instr_reg_clk} = st_q.t2grp;
    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_uaddr_t3_load: assert property (load_t3 |=> st_q.uaddr == $past(next_addr))
        else $error("microaddress not loaded at t3");
    a_t1_capture: assert property (cap_t1 |=> fp_start == $past(rom_word[67])
        && alu_ctl == $past(rom_word[17:15]))
        else $error("t1 group not captured");
    a_t2_capture: assert property (cap_t2 |=> {busreg_clk, instr_reg_clk}
        == $past({rom_word[63], rom_word[46]}))
        else $error("t2 group not captured");
    a_pad_hold_t1: assert property (timing_pulse[0] && !cap_t1 |-> $stable(st_q.pad))
        else $error("pad controls changed during t1");
    a_pulse_spacing: assert property ($rose(timing_pulse[0])
        |-> ##6 $rose(timing_pulse[1]))
        else $error("t2 not 30 ns after t1");
    a_pulse_width: assert property ($rose(timing_pulse[1])
        |-> timing_pulse[1] [*3] ##1 !timing_pulse[1])
        else $error("pulse not 15 ns wide");
    a_polarity_pair: assert property (cap_t1 |=> shift_count_ctl0_n == !$past(rom_word[33])
        && misc_ctl0_n == !$past(rom_word[27]) && misc_ctl[0] == $past(rom_word[27]))
        else $error("complement outputs disagree");
    a_addr_base: assert property (load_t3
        |=> (st_q.uaddr & $past(rom_word[7:0])) == $past(rom_word[7:0]))
        else $error("next address lost base bits");
    a_fork_onehot: assert property ($onehot0({fork_a_enable, fork_b_enable, fork_c_enable}))
        else $error("more than one fork enabled");
    a_t2_before_t3: assert property (cap_t2 |=> ##1 $stable(st_q.t2grp) [*5])
        else $error("t2 group moved before t3");
    a_write_resp: assert property (st_q.aw_got && st_q.w_got |=> s_axi_bvalid)
        else $error("write response missing");

    c_full_cycle: cover property (load_t3 ##1 !cap_t1 [*1] ##[1:40] cap_t2);
    c_fork_taken: cover property (load_t3 && fork_a_enable);
    c_ctrl_write: cover property (st_q.aw_got && st_q.w_got
        && reg_sel(st_q.awaddr) == mcsb_pkg::SEL_CTRL);
    c_conflict_set: cover property ($rose(st_q.conflict));

endmodule

// [sim/mcsb_partner.sv]
// far-side model: branch result and fork address sources
`timescale 1ns/1ps

module mcsb_partner #(
    parameter logic [7:0] FA = 8'h40
) (
    // clock
    input  wire logic       aclk,
    // fork enables from the store, branch result chosen by the bench
    input  wire logic       fork_a_enable,
    input  wire logic       fork_b_enable,
    input  wire logic       fork_c_enable,
    input  wire logic [7:0] branch_req,
    // sequencing inputs of the store
    output logic [7:0]      branch_mod,
    output logic [7:0]      fork_a_addr,
    output logic [7:0]      fork_b_addr,
    output logic [7:0]      fork_c_addr
);
    logic [7:0] churn_q = 8'h5a;

    // an idle fork drives a value that moves every cycle, never a held one
    always @(posedge aclk) begin
        churn_q <= {churn_q[6:0], churn_q[7] ^ churn_q[5]};
    end
    assign branch_mod  = branch_req;
    assign fork_a_addr = fork_a_enable ? FA : churn_q;
    assign fork_b_addr = fork_b_enable ? ~FA : churn_q;
    assign fork_c_addr = fork_c_enable ? FA ^ 8'h30 : churn_q;
endmodule

// [sim/microcode_store_and_buffer_bench.sv]
// self-checking bench for the microcode store and buffer
`timescale 1ns/1ps

module microcode_store_and_buffer_bench;
    // ------------------------------------------------------------
    // signals, image and masks
    // ------------------------------------------------------------
    localparam int NP = 5;
    localparam logic [7:0] FA = 8'h40;
    localparam logic [67:0] M_T1 = {4'hf, 23'h0, 26'h3ffffff, 15'h0};
    localparam logic [67:0] M_PAD = {22'h0, 5'h1f, 41'h0};
    localparam logic [67:0] M_T2 = {4'h0, 18'h3ffff, 46'h0};
    localparam logic [67:0] M_UB = {53'h0, 7'h7f, 8'h0};
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, branch_req = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf, branch_enable;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, branch_enable_n;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, fp_control, bus_delay, busaddr_mux;
    logic [1:0] internal_bus_sel, shift_count_ctl, a_mux, b_mux, const_mux, srcreg_mux;
    logic [1:0] gpr_write_enable, dstreg_mux, dstreg_clk, pc_b_clk, shifter_ctl;
    logic [7:0] branch_mod, fork_a_addr, fork_b_addr, fork_c_addr;
    logic fork_a_enable, fork_b_enable, fork_c_enable, fp_start, clear_sync, pc_a_clk;
    logic shift_count_ctl0_n, misc_ctl0_n, busreg_clk, busreg_mux, srcreg_clk, instr_reg_clk;
    logic [2:0] bus_ctl, misc_ctl, bus_cond, alu_ctl, scratchpad_addr, cc_load;
    logic [NP-1:0] timing_pulse;
    logic [7:0] ua = 8'h00;
    logic [67:0] prev;
    int err_total = 0, checks_done = 0, cyc = 0;

    function automatic logic [67:0] word_of(logic [7:0] v);
        return {v[3:0], v, ~v, v ^ 8'ha5, v, ~v, v ^ 8'h3c, v[0],
                (v == 8'h03) ? 3'b001 : 3'b000, v[3:0], v + 8'h01};
    endfunction
    function automatic logic [256*68-1:0] build_image();
        logic [256*68-1:0] img;
        for (int a = 0; a < 256; a++) begin
            img[a*68 +: 68] = word_of(8'(a));
        end
        return img;
    endfunction
    function automatic logic [67:0] obs();
        return {fp_start, clear_sync, fp_control, busreg_clk, busreg_mux, srcreg_mux,
                dstreg_mux, srcreg_clk, dstreg_clk, cc_load, pc_a_clk, pc_b_clk, shifter_ctl,
                instr_reg_clk, gpr_write_enable, scratchpad_addr, bus_delay, busaddr_mux,
                internal_bus_sel, shift_count_ctl, bus_ctl, misc_ctl, bus_cond, a_mux, b_mux,
                const_mux, alu_ctl, fork_c_enable, fork_b_enable, fork_a_enable,
                branch_enable, 8'h00};
    endfunction

    mcsb_store #(.NUM_PULSES(NP), .ROM_IMAGE(build_image())) dut_u (
        .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
        .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .branch_mod, .fork_a_addr, .fork_b_addr, .fork_c_addr, .fork_a_enable,
        .fork_b_enable, .fork_c_enable, .branch_enable, .branch_enable_n, .timing_pulse,
        .fp_start, .clear_sync, .fp_control, .bus_delay, .busaddr_mux, .internal_bus_sel,
        .shift_count_ctl, .shift_count_ctl0_n, .bus_ctl, .misc_ctl, .misc_ctl0_n,
        .bus_cond, .a_mux, .b_mux, .const_mux, .alu_ctl, .gpr_write_enable,
        .scratchpad_addr, .busreg_clk, .busreg_mux, .srcreg_mux, .dstreg_mux, .srcreg_clk,
        .dstreg_clk, .cc_load, .pc_a_clk, .pc_b_clk, .shifter_ctl, .instr_reg_clk);
    mcsb_partner #(.FA(FA)) far_u (.aclk, .fork_a_enable, .fork_b_enable, .fork_c_enable,
        .branch_req, .branch_mod, .fork_a_addr, .fork_b_addr, .fork_c_addr);

    // ------------------------------------------------------------
    // clock, timeout and tasks
    // ------------------------------------------------------------
    always #2.5 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_total = err_total + 1;
            report_and_stop();
        end
    end

    task automatic cmp(string what, logic [67:0] exp, logic [67:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic axi(bit wr, logic [7:0] a, logic [31:0] d, logic [1:0] er);
        bit aw, wd, ar, hs;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_bready <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready <= !wr;
        hs = 1'b0;
        while (!hs) begin
            @(negedge aclk);
            aw = s_axi_awvalid & s_axi_awready;
            wd = s_axi_wvalid & s_axi_wready;
            ar = s_axi_arvalid & s_axi_arready;
            hs = wr ? (s_axi_bvalid === 1'b1) : (s_axi_rvalid === 1'b1);
            if (hs) cmp("resp", 68'({er, wr ? 32'h0 : d}),
                        68'({wr ? s_axi_bresp : s_axi_rresp, wr ? 32'h0 : s_axi_rdata}));
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (wd) s_axi_wvalid <= 1'b0;
            if (ar) s_axi_arvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
    endtask
    task automatic wait_rise(int k);
        @(negedge aclk);
        while (timing_pulse[k] === 1'b1) @(negedge aclk);
        while (timing_pulse[k] !== 1'b1) @(negedge aclk);
    endtask
    task automatic mcycle(bit first);
        logic [67:0] w;
        w = word_of(ua);
        if (!first) begin
            wait_rise(0);
            repeat (2) @(negedge aclk);
            cmp("t1 group", w & M_T1, obs() & M_T1);
            cmp("pad early", prev & M_PAD, obs() & M_PAD);
            cmp("t2 early", prev & M_T2, obs() & M_T2);
        end
        wait_rise(2);
        cmp("word", w & (M_T1 | M_PAD | M_T2 | M_UB), obs());
        cmp("polarity", {63'h0, ~w[33], ~w[27], ~w[11], ~w[9], ~w[8]},
            {63'h0, shift_count_ctl0_n, misc_ctl0_n, branch_enable_n});
        prev = w;
        ua = w[7:0] | branch_req | (w[12] ? FA : 8'h00);
    endtask
    task automatic pulse_shape();
        wait_rise(0);
        for (int p = 0; p < NP * 6; p++) begin
            cmp("pulses", 68'((p % 6 < 3) ? (1 << (p / 6)) : 0), 68'(timing_pulse));
            @(negedge aclk);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        cmp("reset", word_of(8'h00) & M_UB, obs());
        @(posedge aclk);
        aresetn <= 1'b1;
        axi(1'b0, 8'h00, 32'h1, 2'b00);
        axi(1'b0, 8'h0c, 32'h0, 2'b10);
        axi(1'b1, 8'h0c, 32'h0, 2'b10);
        axi(1'b1, 8'h00, 32'h200, 2'b00);
        axi(1'b0, 8'h04, 32'h2, 2'b00);
        @(negedge aclk);
        cmp("idle pulses", 68'h0, 68'(timing_pulse));
        axi(1'b1, 8'h00, 32'h201, 2'b00);
        ua = 8'h02;
        mcycle(1'b1);
        mcycle(1'b0);
        mcycle(1'b0);
        @(posedge aclk);
        branch_req <= 8'h80;
        mcycle(1'b0);
        @(posedge aclk);
        branch_req <= 8'h00;
        mcycle(1'b0);
        pulse_shape();
        axi(1'b0, 8'h08, 32'h6, 2'b00);
        report_and_stop();
    end
endmodule
